// ==== hw/trim_regs.vh ====
// register map, field layout and reset values of the core trim bank
// assumes byte-addressed register port with 12-bit offsets
`ifndef TRIM_REGS_VH
`define TRIM_REGS_VH
`define ADDR_W 12
`define OFF_CORE_A_TIMING 12'h086
`define OFF_C_FOR_A_TIMING 12'h087
`define OFF_C_FOR_B_TIMING 12'h088
`define OFF_CORE_B_TIMING 12'h089
`define OFF_IN_A_OFFSET_LO 12'h08a
`define OFF_IN_A_OFFSET_HI 12'h08b
`define OFF_IN_B_OFFSET_LO 12'h08c
`define OFF_IN_B_OFFSET_HI 12'h08d
`define OFF_CAL_STATUS 12'h0f0
`define TIMING_W 8
`define OFFSET_W 12
`define OFFSET_RSVD_W 4
`define OFFSET_RSVD_RST 4'h0
`define NUM_TRIM 4
`define SEL_A 2'h0
`define SEL_CA 2'h1
`define SEL_CB 2'h2
`define SEL_B 2'h3
`endif

// ==== hw/trim_select.v ====
// picks the timing trim for one sampling core in dual-channel mode
// assumes core ids 0=A 1=B 2=C; c_for_b set when C stands in for B
module trim_select #(
  parameter W = 8
) (
  input wire [1:0] core_id,
  input wire dual_mode,
  input wire c_for_b,
  input wire [4*W-1:0] trims,
  output reg [W-1:0] trim_out,
  output reg trim_valid
);
  always @* begin
    trim_out = {W{1'b0}};
    trim_valid = dual_mode;
    case (core_id)
      2'h0: trim_out = trims[0*W +: W];
      2'h1: trim_out = trims[3*W +: W];
      2'h2: trim_out = c_for_b ? trims[2*W +: W] : trims[1*W +: W];
      default: trim_valid = 1'b0;
    endcase
    // single-channel trims live in another bank
    if (!dual_mode) begin
      trim_out = {W{1'b0}};
    end
  end
endmodule // trim_select

// ==== hw/core_timing_offset_trim_regs.v ====
// dual-channel timing trims and core A offset trims with register port
// assumes factory trim values arrive as straps, held stable during reset
//
// Decided for this implementation: the strobed register port.
`include "trim_regs.vh"
module core_timing_offset_trim_regs #(
  parameter TW = 8,
  parameter OW = 12
) (
  input wire mclk,
  input wire rst,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  input wire [4*TW-1:0] factory_timing,
  input wire [2*OW-1:0] factory_offset,
  input wire dual_mode,
  input wire [1:0] sampling_core,
  input wire c_for_b,
  input wire bg_phase_alt,
  input wire foreground_cal_busy,
  input wire background_cal_enable,
  input wire background_offset_cal_enable,
  input wire offset_cal_enable,
  input wire foreground_done_flag,
  input wire calibration_stopped_flag,
  output reg [TW-1:0] core_timing_trim,
  output reg core_timing_valid,
  output reg [OW-1:0] core_a_offset,
  input wire analog_input_b,
  output wire offset_write_hazard,
  output wire offset_read_hazard
);
  reg loaded_ff;
  reg [TW-1:0] timing_ff [0:3];
  reg [15:0] offset_ff [0:1];
  reg [15:0] nxt_offset [0:1];
  wire [4*TW-1:0] timing_flat;
  wire [TW-1:0] sel_trim;
  wire sel_valid;
  reg [7:0] nxt_rdata;
  wire off_acc;
  wire off_rd;
  wire off_wr;
  integer k;

  assign off_acc = (addr >= `OFF_IN_A_OFFSET_LO) &&
                   (addr <= `OFF_IN_B_OFFSET_HI);
  assign off_rd = rd_stb && off_acc;
  assign off_wr = wr_stb && off_acc;
  // flags only; the writes still land so software keeps full control
  assign offset_write_hazard = off_wr && (foreground_cal_busy ||
    (background_cal_enable && background_offset_cal_enable));
  assign offset_read_hazard = off_rd &&
    ((offset_cal_enable && !background_offset_cal_enable &&
      !foreground_done_flag) ||
     (background_cal_enable && background_offset_cal_enable &&
      !calibration_stopped_flag));

  // timing trims: index 0=A 1=C for A 2=C for B 3=B
  genvar g;
  generate
    for (g = 0; g < `NUM_TRIM; g = g + 1) begin : g_t
      wire hit;
      assign hit = wr_stb && (addr == `OFF_CORE_A_TIMING + g);
      assign timing_flat[g*TW +: TW] = timing_ff[g];
      // reset to zero then capture straps on first clock after release
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          timing_ff[g] <= {TW{1'b0}};
        end else if (!loaded_ff) begin
          timing_ff[g] <= factory_timing[g*TW +: TW];
        end else if (hit) begin
          timing_ff[g] <= wdata[TW-1:0];
        end
      end
    end
  endgenerate

  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      nxt_offset[k] = offset_ff[k];
      if (wr_stb && (addr == `OFF_IN_A_OFFSET_LO + 2*k)) begin
        nxt_offset[k][7:0] = wdata;
      end
      if (wr_stb && (addr == `OFF_IN_A_OFFSET_HI + 2*k)) begin
        nxt_offset[k][15:8] = wdata;
      end
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      loaded_ff <= 1'b0;
      offset_ff[0] <= 16'h0000;
      offset_ff[1] <= 16'h0000;
    end else if (!loaded_ff) begin
      loaded_ff <= 1'b1;
      offset_ff[0] <= {`OFFSET_RSVD_RST, factory_offset[0 +: OW]};
      offset_ff[1] <= {`OFFSET_RSVD_RST, factory_offset[OW +: OW]};
    end else begin
      offset_ff[0] <= nxt_offset[0];
      offset_ff[1] <= nxt_offset[1];
    end
  end

  trim_select #(
    .W(TW)
  ) u_sel (
    .core_id(sampling_core),
    .dual_mode(dual_mode),
    .c_for_b(c_for_b),
    .trims(timing_flat),
    .trim_out(sel_trim),
    .trim_valid(sel_valid)
  );

  // background phase alt on core C picks the C for B or C for A trim per c_for_b, the same trim as sel_trim
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      core_timing_trim <= {TW{1'b0}};
      core_timing_valid <= 1'b0;
      core_a_offset <= {OW{1'b0}};
    end else begin
      core_timing_valid <= sel_valid && loaded_ff;
      if (bg_phase_alt && dual_mode && sampling_core == 2'h2) begin
        core_timing_trim <= c_for_b ? timing_ff[2] : timing_ff[1];
      end else begin
        core_timing_trim <= sel_trim;
      end
      core_a_offset <= analog_input_b ? offset_ff[1][OW-1:0] :
                                        offset_ff[0][OW-1:0];
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    case (addr)
      `OFF_CORE_A_TIMING: nxt_rdata = timing_ff[0];
      `OFF_C_FOR_A_TIMING: nxt_rdata = timing_ff[1];
      `OFF_C_FOR_B_TIMING: nxt_rdata = timing_ff[2];
      `OFF_CORE_B_TIMING: nxt_rdata = timing_ff[3];
      `OFF_IN_A_OFFSET_LO: nxt_rdata = offset_ff[0][7:0];
      `OFF_IN_A_OFFSET_HI: nxt_rdata = offset_ff[0][15:8];
      `OFF_IN_B_OFFSET_LO: nxt_rdata = offset_ff[1][7:0];
      `OFF_IN_B_OFFSET_HI: nxt_rdata = offset_ff[1][15:8];
      `OFF_CAL_STATUS: nxt_rdata = {4'h0, calibration_stopped_flag,
        foreground_done_flag, loaded_ff, dual_mode};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      rdata <= nxt_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // core_timing_offset_trim_regs

// ==== sim/trim_regs_checker.sv ====
// port assertions for the trim bank
// assumes one clock mclk, async active-high rst
module trim_regs_checker (
  input logic mclk, rst, wr_stb, rd_stb, dual_mode, core_timing_valid,
  input logic [11:0] addr,
  input logic [7:0] rdata,
  input logic [1:0] sampling_core,
  input logic foreground_cal_busy, background_cal_enable,
  input logic background_offset_cal_enable, offset_write_hazard,
  input logic offset_cal_enable, foreground_done_flag,
  input logic calibration_stopped_flag, offset_read_hazard
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire offs = addr >= 12'h08a && addr <= 12'h08d;
  wire bad = foreground_cal_busy ||
    (background_cal_enable && background_offset_cal_enable);
  a_rdata_idle_zero: assert property (!rd_stb |=> rdata == 8'h00)
    else $error("rdata not zero");
  a_single_no_valid: assert property (!dual_mode |=> !core_timing_valid)
    else $error("valid in single mode");
  a_none_no_valid: assert property (
    sampling_core == 2'h3 |=> !core_timing_valid)
    else $error("valid with no core");
  a_valid_dual_core: assert property (
    (dual_mode && sampling_core != 2'h3) [*2] |=> core_timing_valid)
    else $error("valid missing");
  a_read_hazard_on: assert property (
    rd_stb && offs && ((offset_cal_enable && !background_offset_cal_enable &&
    !foreground_done_flag) || (background_cal_enable &&
    background_offset_cal_enable && !calibration_stopped_flag))
    |-> offset_read_hazard)
    else $error("read hazard not flagged");
  a_write_hazard_on: assert property (wr_stb && offs && bad
    |-> offset_write_hazard)
    else $error("hazard not flagged");
  a_hazard_needs_wr: assert property (!wr_stb |-> !offset_write_hazard)
    else $error("hazard without write");
endmodule // trim_regs_checker
bind core_timing_offset_trim_regs trim_regs_checker i_chk (.*);

// ==== sim/tb_top.sv ====
// self-checking bench for the trim bank
// assumes reads answer one cycle after the strobe
`define CHK(a, e) begin samples_checked++; \
  if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, wr_stb = 0, rd_stb = 0, dual_mode = 0, c_for_b = 0;
  logic bg_phase_alt = 0, foreground_cal_busy = 0, background_cal_enable = 0;
  logic background_offset_cal_enable = 0, offset_cal_enable = 0;
  logic foreground_done_flag = 0, calibration_stopped_flag = 0;
  logic analog_input_b = 0, core_timing_valid;
  logic offset_write_hazard, offset_read_hazard, hz, rh;
  logic [11:0] addr = 0, core_a_offset;
  logic [7:0] wdata = 0, rdata, core_timing_trim, d;
  logic [1:0] sampling_core = 0;
  logic [31:0] factory_timing = 32'h44332211;
  logic [23:0] factory_offset = 24'hbcd9a8;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  // wr, addr, wdata, expected read
  logic [28:0] rows [14] = '{29'h0086_0011, 29'h0087_0022, 29'h0088_0033,
    29'h0089_0044, 29'h008a_00a8, 29'h008b_0009, 29'h008c_00cd,
    29'h008d_000b, 29'h1087_5a00, 29'h0087_005a, 29'h108d_ff00,
    29'h008d_00ff, 29'h10a0_7700, 29'h00a0_0000};
  logic [7:0] exp_t [4] = '{8'h11, 8'h44, 8'h5a, 8'h33};
  core_timing_offset_trim_regs i_dut (.*);
  always #5 mclk = ~mclk;
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    #1 hz = offset_write_hazard;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    #1 rh = offset_read_hazard;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      if (rows[i][28]) wr(rows[i][27:16], rows[i][15:8]);
      else begin
        rd(rows[i][27:16]);
        `CHK(d, rows[i][7:0])
      end
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      dual_mode <= 1'b1;
      sampling_core <= (k == 3) ? 2'h2 : k[1:0];
      c_for_b <= k == 3;
      bg_phase_alt <= k[0];
      settle();
      `CHK(core_timing_trim, exp_t[k])
      `CHK(core_timing_valid, 1'b1)
    end
    @(posedge mclk);
    sampling_core <= 2'h3;
    settle();
    `CHK(core_timing_valid, 1'b0)
    @(posedge mclk);
    sampling_core <= 2'h0;
    dual_mode <= 1'b0;
    analog_input_b <= 1'b1;
    settle();
    `CHK(core_timing_valid, 1'b0)
    `CHK(core_a_offset, 12'hfcd)
    @(posedge mclk);
    foreground_cal_busy <= 1'b1;
    offset_cal_enable <= 1'b1;
    wr(12'h08a, 8'h3c);
    `CHK(hz, 1'b1)
    foreground_cal_busy <= 1'b0;
    background_cal_enable <= 1'b1;
    background_offset_cal_enable <= 1'b1;
    wr(12'h08b, 8'h05);
    `CHK(hz, 1'b1)
    rd(12'h08b);
    `CHK(d, 8'h05)
    `CHK(rh, 1'b1)
    @(posedge mclk);
    calibration_stopped_flag <= 1'b1;
    rd(12'h08a);
    `CHK(rh, 1'b0)
    `CHK(d, 8'h3c)
    @(posedge mclk);
    background_cal_enable <= 1'b0;
    background_offset_cal_enable <= 1'b0;
    rd(12'h08c);
    `CHK(rh, 1'b1)
    @(posedge mclk);
    foreground_done_flag <= 1'b1;
    rd(12'h08c);
    `CHK(rh, 1'b0)
    wr(12'h08c, 8'h11);
    `CHK(hz, 1'b0)
    @(posedge mclk);
    analog_input_b <= 1'b0;
    settle();
    `CHK(core_a_offset, 12'h53c)
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK(rdata, 8'h00)
    `CHK(core_a_offset, 12'h000)
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(12'h087);
    `CHK(d, 8'h22)
    rd(12'h08d);
    `CHK(d, 8'h0b)
    summarize();
  end
endmodule // tb_top
